// ### rtl/pss_pkg.sv
// constants, commands and alu types for the program sequencer
package pss_pkg;
  localparam int PC_W = 11;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int STK_DEPTH = 6;
  localparam int STK_IDX_W = 3;
  localparam logic [10:0] RESET_VEC = 11'h000;
  localparam logic [2:0] LAST_PAGE = 3'h7;
  localparam logic [7:0] ADDR_PC_LOW = 8'h06;
  localparam logic [7:0] ADDR_TBLP = 8'h07;
  localparam logic [7:0] ADDR_TAB_HIGH = 8'h08;
  localparam logic [7:0] ADDR_TBHP = 8'h09;
  localparam logic [7:0] TBLP_RST = 8'h00;
  localparam logic [2:0] TBHP_RST = 3'h0;
  localparam logic [7:0] TAB_HIGH_RST = 8'h00;
  localparam logic [7:0] TAB_HIGH_USED = 8'hFF;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam logic [3:0] UPD_ARITH = 4'hF;
  localparam logic [3:0] UPD_Z = 4'h4;
  localparam logic [3:0] UPD_C = 4'h1;
  localparam logic [3:0] UPD_NONE = 4'h0;

  typedef enum logic [2:0] {
    CMD_NEXT, CMD_JMP, CMD_CALL, CMD_SUB_RETURN, CMD_INT_RETURN, CMD_TABRD, CMD_TAB_LAST
  } pss_cmd_e;

  typedef enum logic [4:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR, ALU_CPL,
    ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_SZ, ALU_SNZ, ALU_SIZ, ALU_SDZ
  } pss_alu_op_e;

  typedef struct packed {
    logic [7:0] res;
    logic [3:0] flags;
    logic [3:0] upd;
    logic wr;
    logic skip;
  } pss_alu_s;
endpackage

// ### rtl/pss_sequencer.sv
// program sequencer: pc, return stack, interrupt deferral, table read, alu
`timescale 1ns/1ns
module pss_sequencer #(
  parameter logic [7:0] TAB_HIGH_MASK = pss_pkg::TAB_HIGH_USED
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  output logic [pss_pkg::PC_W-1:0] flash_addr_o,
  input wire logic [pss_pkg::WORD_W-1:0] flash_data_i,
  output logic [pss_pkg::WORD_W-1:0] instr_o,
  output logic instr_valid_o,
  input wire pss_pkg::pss_cmd_e cmd_i,
  input wire logic [pss_pkg::PC_W-1:0] target_i,
  input wire logic skip_i,
  input wire logic [7:0] tab_dest_i,
  input wire logic dm_wr_i,
  input wire logic [7:0] dm_addr_i,
  input wire logic [7:0] dm_wdata_i,
  output logic [7:0] dm_rdata_o,
  output logic tab_wr_o,
  output logic [7:0] tab_dest_o,
  output logic [7:0] tab_data_o,
  input wire logic irq_i,
  input wire logic [pss_pkg::PC_W-1:0] irq_vector_i,
  output logic irq_pend_o,
  output logic irq_ack_o,
  output logic irq_exit_o,
  input wire logic alu_valid_i,
  input wire pss_pkg::pss_alu_op_e alu_op_i,
  input wire logic [7:0] alu_a_i,
  input wire logic [7:0] alu_b_i,
  input wire logic alu_dest_mem_i,
  output logic [7:0] alu_res_o,
  output logic alu_wr_o,
  output logic alu_dest_mem_o,
  output logic [3:0] status_o
);
  import pss_pkg::*;

  typedef enum logic {ST_RUN, ST_TAB} pss_state_e;

  function automatic logic [STK_IDX_W-1:0] stk_inc(input logic [STK_IDX_W-1:0] i);
    stk_inc = (i == STK_IDX_W'(STK_DEPTH - 1)) ? '0 : i + 1'b1;
  endfunction

  function automatic logic [STK_IDX_W-1:0] stk_dec(input logic [STK_IDX_W-1:0] i);
    stk_dec = (i == '0) ? STK_IDX_W'(STK_DEPTH - 1) : i - 1'b1;
  endfunction

  function automatic pss_alu_s alu_calc(input pss_alu_op_e op, input logic [7:0] a,
                                        input logic [7:0] b, input logic [3:0] st);
    pss_alu_s r;
    logic [8:0] s;
    logic [4:0] h;
    logic cin;
    r = '0;
    s = '0;
    h = '0;
    cin = st[FLAG_C];
    r.wr = 1'b1;
    r.upd = UPD_Z;
    unique case (op)
      ALU_ADD, ALU_ADC: begin
        cin = (op == ALU_ADC) ? st[FLAG_C] : 1'b0;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r.res = s[7:0];
        r.flags[FLAG_C] = s[8];
        r.flags[FLAG_AC] = h[4];
        r.flags[FLAG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
        r.upd = UPD_ARITH;
      end
      ALU_SUB, ALU_SBC: begin
        // carry set means no borrow
        cin = (op == ALU_SBC) ? st[FLAG_C] : 1'b1;
        s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        r.res = s[7:0];
        r.flags[FLAG_C] = s[8];
        r.flags[FLAG_AC] = h[4];
        r.flags[FLAG_OV] = (a[7] != b[7]) && (s[7] != a[7]);
        r.upd = UPD_ARITH;
      end
      ALU_DAA: begin
        s = {1'b0, a};
        if (a[3:0] > 4'h9 || st[FLAG_AC]) begin
          s = s + 9'h006;
        end
        if (s[7:4] > 4'h9 || s[8] || st[FLAG_C]) begin
          s = s + 9'h060;
        end
        r.res = s[7:0];
        r.flags[FLAG_C] = s[8] | st[FLAG_C];
        r.upd = UPD_C;
      end
      ALU_AND: r.res = a & b;
      ALU_OR: r.res = a | b;
      ALU_XOR: r.res = a ^ b;
      ALU_CPL: r.res = ~b;
      ALU_RR: begin
        r.res = {b[0], b[7:1]};
        r.upd = UPD_NONE;
      end
      ALU_RL: begin
        r.res = {b[6:0], b[7]};
        r.upd = UPD_NONE;
      end
      ALU_RRC: begin
        r.res = {st[FLAG_C], b[7:1]};
        r.flags[FLAG_C] = b[0];
        r.upd = UPD_C;
      end
      ALU_RLC: begin
        r.res = {b[6:0], st[FLAG_C]};
        r.flags[FLAG_C] = b[7];
        r.upd = UPD_C;
      end
      ALU_INC, ALU_SIZ: r.res = b + 8'h01;
      ALU_DEC, ALU_SDZ: r.res = b - 8'h01;
      ALU_SZ, ALU_SNZ: begin
        r.res = b;
        r.wr = 1'b0;
      end
    endcase
    r.flags[FLAG_Z] = (r.res == 8'h00);
    if (op == ALU_SZ || op == ALU_SIZ || op == ALU_SDZ) begin
      r.skip = r.flags[FLAG_Z];
      r.upd = UPD_NONE;
    end
    if (op == ALU_SNZ) begin
      r.skip = !r.flags[FLAG_Z];
      r.upd = UPD_NONE;
    end
    return r;
  endfunction

  pss_state_e state_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] stk_mem_reg [STK_DEPTH];
  logic [STK_IDX_W-1:0] stk_wp_reg;
  logic [STK_IDX_W-1:0] stk_cnt_reg;
  logic [7:0] tblp_reg;
  logic [2:0] tbhp_reg;
  logic [7:0] tab_high_reg;
  logic exec;
  logic stk_full;
  logic pc_low_wr;
  logic do_tab;
  logic do_jmp;
  logic do_call;
  logic do_pop;
  logic do_skip;
  logic do_irq;
  logic do_push;
  logic [PC_W-1:0] stk_top;
  pss_alu_s alu_r;

  assign alu_r = alu_calc(alu_op_i, alu_a_i, alu_b_i, status_o);
  assign stk_top = stk_mem_reg[stk_dec(stk_wp_reg)];
  assign stk_full = (stk_cnt_reg == STK_IDX_W'(STK_DEPTH));

  // decode stage only acts on a real instruction, never in a dummy cycle
  always_comb begin
    exec = instr_valid_o && (state_reg == ST_RUN);
    pc_low_wr = exec && dm_wr_i && (dm_addr_i == ADDR_PC_LOW);
    do_tab = exec && (cmd_i == CMD_TABRD || cmd_i == CMD_TAB_LAST);
    do_jmp = exec && (cmd_i == CMD_JMP);
    do_call = exec && (cmd_i == CMD_CALL);
    do_pop = exec && (cmd_i == CMD_SUB_RETURN || cmd_i == CMD_INT_RETURN);
    do_skip = exec && (skip_i || (alu_valid_i && alu_r.skip));
    // acknowledge withheld while all levels are used
    do_irq = exec && irq_pend_o && !stk_full && (cmd_i == CMD_NEXT) && !pc_low_wr && !do_skip;
    do_push = do_call || do_irq;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_RUN;
      pc_reg <= RESET_VEC;
      flash_addr_o <= RESET_VEC;
      instr_o <= '0;
      instr_valid_o <= 1'b0;
    end else begin
      state_reg <= ST_RUN;
      instr_o <= flash_data_i;
      instr_valid_o <= 1'b1;
      pc_reg <= pc_reg + 1'b1;
      flash_addr_o <= pc_reg + 1'b1;
      if (state_reg == ST_TAB) begin
        // second table cycle: refetch the word skipped for the table access
        instr_valid_o <= 1'b0;
        pc_reg <= pc_reg;
        flash_addr_o <= pc_reg;
      end else if (do_tab) begin
        state_reg <= ST_TAB;
        instr_valid_o <= 1'b0;
        pc_reg <= pc_reg;
        flash_addr_o <= {(cmd_i == CMD_TAB_LAST) ? LAST_PAGE : tbhp_reg, tblp_reg};
      end else if (do_jmp || do_call) begin
        instr_valid_o <= 1'b0;
        pc_reg <= target_i;
        flash_addr_o <= target_i;
      end else if (do_pop) begin
        instr_valid_o <= 1'b0;
        pc_reg <= stk_top;
        flash_addr_o <= stk_top;
      end else if (pc_low_wr) begin
        instr_valid_o <= 1'b0;
        pc_reg <= {pc_reg[PC_W-1:8], dm_wdata_i};
        flash_addr_o <= {pc_reg[PC_W-1:8], dm_wdata_i};
      end else if (do_skip) begin
        instr_valid_o <= 1'b0;
      end else if (do_irq) begin
        instr_valid_o <= 1'b0;
        pc_reg <= irq_vector_i;
        flash_addr_o <= irq_vector_i;
      end
    end
  end

  // ring of six: a push on a full stack overwrites the oldest entry
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      stk_wp_reg <= '0;
      stk_cnt_reg <= '0;
    end else if (do_push) begin
      stk_wp_reg <= stk_inc(stk_wp_reg);
      if (!stk_full) begin
        stk_cnt_reg <= stk_cnt_reg + 1'b1;
      end
    end else if (do_pop) begin
      stk_wp_reg <= stk_dec(stk_wp_reg);
      if (stk_cnt_reg != '0) begin
        stk_cnt_reg <= stk_cnt_reg - 1'b1;
      end
    end
  end

  // storage has no data-bus path at all
  always_ff @(posedge clk_sys_i) begin
    if (do_push) begin
      stk_mem_reg[stk_wp_reg] <= pc_reg;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      irq_pend_o <= 1'b0;
      irq_ack_o <= 1'b0;
      irq_exit_o <= 1'b0;
    end else begin
      irq_pend_o <= irq_i || (irq_pend_o && !do_irq);
      irq_ack_o <= do_irq;
      irq_exit_o <= exec && (cmd_i == CMD_INT_RETURN);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tblp_reg <= TBLP_RST;
      tbhp_reg <= TBHP_RST;
    end else if (exec && dm_wr_i) begin
      if (dm_addr_i == ADDR_TBLP) begin
        tblp_reg <= dm_wdata_i;
      end
      if (dm_addr_i == ADDR_TBHP) begin
        tbhp_reg <= dm_wdata_i[2:0];
      end
    end
  end

  // software writes to the high-byte register are dropped
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tab_high_reg <= TAB_HIGH_RST;
      tab_wr_o <= 1'b0;
      tab_dest_o <= '0;
      tab_data_o <= '0;
    end else begin
      tab_wr_o <= 1'b0;
      if (do_tab) begin
        tab_dest_o <= tab_dest_i;
      end
      if (state_reg == ST_TAB) begin
        tab_wr_o <= 1'b1;
        tab_data_o <= flash_data_i[7:0];
        tab_high_reg <= flash_data_i[15:8] & TAB_HIGH_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      dm_rdata_o <= '0;
    end else begin
      unique case (dm_addr_i)
        ADDR_PC_LOW: dm_rdata_o <= pc_reg[7:0];
        ADDR_TBLP: dm_rdata_o <= tblp_reg;
        ADDR_TBHP: dm_rdata_o <= {5'h00, tbhp_reg};
        ADDR_TAB_HIGH: dm_rdata_o <= tab_high_reg;
        default: dm_rdata_o <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      alu_res_o <= '0;
      alu_wr_o <= 1'b0;
      alu_dest_mem_o <= 1'b0;
      status_o <= STATUS_RST;
    end else begin
      alu_wr_o <= exec && alu_valid_i && alu_r.wr;
      if (exec && alu_valid_i) begin
        alu_res_o <= alu_r.res;
        alu_dest_mem_o <= alu_dest_mem_i;
        status_o <= (status_o & ~alu_r.upd) | (alu_r.flags & alu_r.upd);
      end
    end
  end
endmodule

// ### test/pss_flash_model.sv
// program flash model: 2K x 16 words, combinational read
`timescale 1ns/1ns
module pss_flash_model
  import pss_pkg::*;
(
  input wire logic [PC_W-1:0] addr_i,
  output logic [WORD_W-1:0] data_o
);
  // both bytes vary with address so a swapped or shifted fetch shows
  assign data_o = {addr_i[7:0], 5'h00, addr_i[10:8]} ^ 16'h5AC3;
endmodule

// ### test/pss_seq_asserts.sv
// concurrent checks on the sequencer top ports
`timescale 1ns/1ns
module pss_seq_asserts
  import pss_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [10:0] flash_addr_o,
  input wire logic instr_valid_o,
  input wire pss_cmd_e cmd_i,
  input wire logic [10:0] target_i,
  input wire logic skip_i,
  input wire logic [7:0] tab_dest_i,
  input wire logic dm_wr_i,
  input wire logic [7:0] dm_addr_i,
  input wire logic [7:0] dm_wdata_i,
  input wire logic tab_wr_o,
  input wire logic [7:0] tab_dest_o,
  input wire logic irq_i,
  input wire logic [10:0] irq_vector_i,
  input wire logic irq_pend_o,
  input wire logic irq_ack_o,
  input wire logic alu_valid_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // plain step: nothing that could redirect the fetch
  wire logic plain = instr_valid_o && cmd_i == CMD_NEXT && !skip_i && !dm_wr_i && !irq_pend_o && !alu_valid_i;
  property p_reset_vec;
    $rose(rst_b_i) |-> flash_addr_o == RESET_VEC && !instr_valid_o;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector");
  property p_seq;
    plain |=> instr_valid_o && flash_addr_o == $past(flash_addr_o) + 11'h1;
  endproperty
  a_seq: assert property (p_seq) else $error("sequential pc");
  property p_jmp;
    instr_valid_o && (cmd_i == CMD_JMP || cmd_i == CMD_CALL)
      |=> !instr_valid_o && flash_addr_o == $past(target_i) ##1 instr_valid_o;
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump timing");
  property p_page_jmp;
    instr_valid_o && cmd_i == CMD_NEXT && dm_wr_i && dm_addr_i == ADDR_PC_LOW
      |=> !instr_valid_o && flash_addr_o == {$past(flash_addr_o[10:8]), $past(dm_wdata_i)};
  endproperty
  a_page_jmp: assert property (p_page_jmp) else $error("page jump");
  property p_skip;
    instr_valid_o && cmd_i == CMD_NEXT && skip_i && !dm_wr_i
      |=> !instr_valid_o && flash_addr_o == $past(flash_addr_o) + 11'h1 ##1 instr_valid_o;
  endproperty
  a_skip: assert property (p_skip) else $error("skip dummy");
  property p_tab;
    instr_valid_o && cmd_i == CMD_TABRD
      |=> !instr_valid_o ##1 (tab_wr_o && !instr_valid_o && tab_dest_o == $past(tab_dest_i, 2)) ##1 instr_valid_o;
  endproperty
  a_tab: assert property (p_tab) else $error("table read cycles");
  property p_tabl;
    instr_valid_o && cmd_i == CMD_TAB_LAST |=> flash_addr_o[10:8] == LAST_PAGE;
  endproperty
  a_tabl: assert property (p_tabl) else $error("last page table");
  property p_pend;
    irq_i |=> irq_pend_o;
  endproperty
  a_pend: assert property (p_pend) else $error("request latch");
  property p_ack;
    irq_ack_o |-> !instr_valid_o && flash_addr_o == $past(irq_vector_i);
  endproperty
  a_ack: assert property (p_ack) else $error("ack vector");
endmodule
bind pss_sequencer pss_seq_asserts u_chk(.*);

// ### test/pss_sequencer_tb_top.sv
// self-checking bench for the program sequencer
`timescale 1ns/1ns
module pss_sequencer_tb_top;
  import pss_pkg::*;
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, instr_valid_o, skip_i = 1'b0, dm_wr_i = 1'b0, tab_wr_o, irq_i = 1'b0;
  logic irq_pend_o, irq_ack_o, irq_exit_o, alu_valid_i = 1'b0, alu_dest_mem_i = 1'b0, alu_wr_o, alu_dest_mem_o;
  logic [10:0] flash_addr_o, target_i = '0, irq_vector_i = 11'h004;
  logic [15:0] flash_data_i, instr_o;
  logic [7:0] tab_dest_i = '0, dm_addr_i = '0, dm_wdata_i = '0, dm_rdata_o, tab_dest_o, tab_data_o;
  logic [7:0] alu_a_i = '0, alu_b_i = '0, alu_res_o;
  logic [3:0] status_o;
  pss_cmd_e cmd_i = CMD_NEXT;
  pss_alu_op_e alu_op_i = ALU_ADD;
  int n_mismatch = 0;
  int comparisons = 0;
  int ack_seen = 0;
  // narrowed mask so unused high table bits are exercised
  pss_sequencer #(.TAB_HIGH_MASK(8'h3F)) DUT(.*);
  pss_flash_model u_flash(.addr_i(flash_addr_o), .data_o(flash_data_i));
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // counted on the falling edge, away from the edge that launches the pulse
  always @(negedge clk_sys_i) if (irq_ack_o === 1'b1) ack_seen++;
  function automatic logic [15:0] fw(input logic [10:0] a);
    return {a[7:0], 5'h00, a[10:8]} ^ 16'h5AC3;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wait_valid();
    int i;
    for (i = 0; i < 30 && instr_valid_o !== 1'b1; i++) cyc(1);
    if (i == 30) begin
      chk("valid wait", 16'h1, 16'h0);
      close_out();
    end
  endtask
  task automatic do_reset();
    rst_b_i = 1'b0;
    cyc(2);
    rst_b_i = 1'b1;
    cyc(1);
  endtask
  task automatic issue(input pss_cmd_e c, input logic [10:0] t, output logic [10:0] ra);
    wait_valid();
    ra = flash_addr_o;
    cmd_i = c;
    target_i = t;
    cyc(1);
    cmd_i = CMD_NEXT;
  endtask
  task automatic dm_write(input logic [7:0] a, input logic [7:0] d);
    wait_valid();
    dm_wr_i = 1'b1;
    dm_addr_i = a;
    dm_wdata_i = d;
    cyc(1);
    dm_wr_i = 1'b0;
  endtask
  task automatic alu_run(input pss_alu_op_e op, input logic [7:0] a, b, r, input logic z);
    wait_valid();
    alu_valid_i = 1'b1;
    alu_op_i = op;
    alu_a_i = a;
    alu_b_i = b;
    alu_dest_mem_i = a[0];
    cyc(1);
    alu_valid_i = 1'b0;
    chk("alu result", {8'h01, r}, {7'h0, alu_wr_o, alu_res_o});
    chk("alu zero", {15'h0, z}, {15'h0, status_o[FLAG_Z]});
    chk("alu dest", {15'h0, a[0]}, {15'h0, alu_dest_mem_o});
    // let an edge pass so the next call does not raise the strobe just lowered
    cyc(1);
  endtask
  task automatic t_stack();
    logic [10:0] ra [7];
    logic [10:0] x;
    do_reset();
    chk("vector word", fw(RESET_VEC), instr_o);
    for (int i = 0; i < 7; i++) begin
      issue(CMD_CALL, 11'h100 + 11'(i * 16), ra[i]);
      chk("call target", {5'h0, 11'h100 + 11'(i * 16)}, {5'h0, flash_addr_o});
      chk("call dummy", 16'h0, {15'h0, instr_valid_o});
    end
    for (int i = 6; i > 0; i--) begin
      issue(CMD_SUB_RETURN, 11'h0, x);
      chk("return addr", {5'h0, ra[i]}, {5'h0, flash_addr_o});
    end
    issue(CMD_JMP, 11'h7FF, x);
    cyc(1);
    chk("pc wrap", 16'h0, {5'h0, flash_addr_o});
    $display("test stack done");
  endtask
  task automatic t_page();
    logic [10:0] x;
    do_reset();
    issue(CMD_JMP, 11'h3FF, x);
    wait_valid();
    x = flash_addr_o;
    dm_write(ADDR_PC_LOW, 8'h25);
    chk("page jump", {5'h0, x[10:8], 8'h25}, {5'h0, flash_addr_o});
    chk("page dummy", 16'h0, {15'h0, instr_valid_o});
    wait_valid();
    x = flash_addr_o;
    skip_i = 1'b1;
    cyc(1);
    skip_i = 1'b0;
    chk("skip dummy", {4'h0, x + 11'h1, 1'b0}, {4'h0, flash_addr_o, instr_valid_o});
    cyc(1);
    chk("after skip", fw(x + 11'h1), instr_o);
    $display("test page jump done");
  endtask
  task automatic t_table();
    logic [10:0] x;
    logic [15:0] w;
    do_reset();
    // interrupts kept off around main-routine table reads
    irq_i = 1'b0;
    dm_write(ADDR_TBLP, 8'h06);
    cyc(1);
    dm_write(ADDR_TBHP, 8'h01);
    tab_dest_i = 8'h42;
    w = fw(11'h706);
    issue(CMD_TAB_LAST, 11'h0, x);
    chk("last page addr", 16'h0706, {5'h0, flash_addr_o});
    cyc(1);
    chk("table low", {8'h42, w[7:0]}, {tab_dest_o, tab_data_o});
    chk("table strobe", 16'h2, {14'h0, tab_wr_o, instr_valid_o});
    dm_addr_i = ADDR_TAB_HIGH;
    cyc(1);
    chk("table high", {8'h0, w[15:8] & 8'h3F}, {8'h0, dm_rdata_o});
    dm_write(ADDR_TAB_HIGH, 8'hFF);
    cyc(1);
    chk("high read only", {8'h0, w[15:8] & 8'h3F}, {8'h0, dm_rdata_o});
    issue(CMD_TABRD, 11'h0, x);
    chk("pointer addr", 16'h0106, {5'h0, flash_addr_o});
    $display("test table done");
  endtask
  task automatic t_irq();
    logic [10:0] x;
    int a0;
    int i;
    do_reset();
    for (i = 0; i < 6; i++) issue(CMD_CALL, 11'h200, x);
    irq_i = 1'b1;
    cyc(1);
    irq_i = 1'b0;
    a0 = ack_seen;
    cyc(6);
    chk("pend held", 16'h1, {15'h0, irq_pend_o});
    chk("ack withheld", 16'(a0), 16'(ack_seen));
    issue(CMD_SUB_RETURN, 11'h0, x);
    for (i = 0; i < 10 && irq_ack_o !== 1'b1; i++) cyc(1);
    chk("ack pulse", 16'h1, {15'h0, irq_ack_o});
    chk("deferred ack", {5'h0, irq_vector_i}, {5'h0, flash_addr_o});
    issue(CMD_INT_RETURN, 11'h0, x);
    chk("return pulse", 16'h1, {15'h0, irq_exit_o});
    $display("test interrupt done");
  endtask
  initial begin
    do_reset();
    t_stack();
    t_page();
    t_table();
    t_irq();
    alu_run(ALU_ADD, 8'h80, 8'h80, 8'h00, 1'b1);
    chk("add carry", 16'h1, {15'h0, status_o[FLAG_C]});
    alu_run(ALU_ADC, 8'h01, 8'h01, 8'h03, 1'b0);
    alu_run(ALU_SUB, 8'h05, 8'h03, 8'h02, 1'b0);
    alu_run(ALU_AND, 8'hF0, 8'h3C, 8'h30, 1'b0);
    alu_run(ALU_XOR, 8'hAA, 8'hAA, 8'h00, 1'b1);
    $display("test alu done");
    close_out();
  end
endmodule
